// ==== hw/lsar_regs.sv ====
// Purpose: Alias remap, check error counter and general link status
// Assumes: Register port strobes and event inputs are synchronous
// Notes: Error-reset bit and remote target address come from outside
//
// What this block does
// - Hold seven-bit alias in alias bits 7:1
// - Matching host access forwarded with target address
// - Zero alias blocks all remote peripheral access
// - Sixteen-bit read-only error count, two bytes
// - Error-reset bit clears both counter bytes
// - Sticky link-lost flag until error reset
// - Self-test error flag; cleared by loss, restart, reset
// - Normal error flag; cleared by loss or reset
// - Status bit 0 shows cable link present
// - Replacement address from remote target field
`timescale 1ns/100ps
module lsar_regs
   import lsar_pkg::*;
#(
   parameter int CNT_W = 16   // Error counter width
) (
   input wire logic i_sys_clk,                  // Control clock
   input wire logic i_arst_n,                   // Async reset, active low
   input wire logic i_reg_wr,                   // Register write strobe
   input wire logic i_reg_rd,                   // Register read strobe
   input wire logic [7:0] i_reg_addr,           // Register offset
   input wire logic [7:0] i_reg_wdata,          // Write data
   output logic [7:0] o_reg_rdata,              // Read data
   output logic o_reg_rvalid,                   // Read data valid pulse
   input wire logic i_error_reset,              // Error-reset control bit
   input wire logic [6:0] i_remote_target_address, // Remote target field
   input wire logic i_host_valid,               // Host transaction start
   input wire logic [6:0] i_host_addr,          // Host bus address
   output logic o_fwd_valid,                    // Forward over back channel
   output logic [6:0] o_fwd_addr,               // Remapped address
   input wire logic i_check_error,              // Back-channel check error
   input wire logic i_selftest_active,          // Self-test exchange running
   input wire logic i_selftest_restart,         // Self-test restart pulse
   input wire logic i_link_detect,              // Cable link present level
   input wire logic i_video_input_clock_present, // Video clock detected
   output logic [6:0] o_remote_target_alias,    // Alias field value
   output logic [7:0] o_general_link_status     // Status byte
);

   // -----------------------------------------------------------------
   // Elaboration check
   // -----------------------------------------------------------------
   if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
      $error("CNT_W must fit two register bytes");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [6:0] alias_reg;          // Alias address
   logic [6:0] alias_next;
   logic [CNT_W-1:0] cnt_reg;      // Check error count
   logic [CNT_W-1:0] cnt_next;
   logic link_reg;                 // Registered link presence
   logic vclk_reg;                 // Registered video clock presence
   logic lost_reg;                 // Sticky link lost
   logic lost_next;
   logic self_err_reg;             // Self-test error flag
   logic self_err_next;
   logic norm_err_reg;             // Normal error flag
   logic norm_err_next;
   logic fwd_valid_reg;            // Forward strobe
   logic [6:0] fwd_addr_reg;       // Forward address
   logic [7:0] rdata_reg;          // Read data
   logic rvalid_reg;               // Read data valid

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   wire logic wr_alias = i_reg_wr && (i_reg_addr == LSAR_OFS_ALIAS);
   // Link loss is the falling edge of the link presence
   wire logic link_loss = link_reg && !i_link_detect;
   // Counter stops at full scale instead of wrapping
   wire logic cnt_full = &cnt_reg;
   wire logic [15:0] cnt_wide = 16'(cnt_reg);
   // Alias hit: zero alias never matches
   wire logic alias_hit = i_host_valid && (alias_reg != 7'h00)
      && (i_host_addr == alias_reg);
   wire logic [7:0] status_byte = {3'h0, lost_reg, self_err_reg,
      vclk_reg, norm_err_reg, link_reg};

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // Alias field takes write data bits 7:1; bit 0 reserved
   assign alias_next = wr_alias ? i_reg_wdata[7:LSAR_ALIAS_LSB]
      : alias_reg;
   // Error reset clears; a same-cycle error still counts as one
   assign cnt_next = i_error_reset ? CNT_W'(i_check_error)
      : (i_check_error && !cnt_full) ? cnt_reg + CNT_W'(1)
      : cnt_reg;
   // Set wins over the error-reset clear
   assign lost_next = link_loss || (lost_reg && !i_error_reset);
   // Self-test error set wins over any clear
   assign self_err_next = (i_check_error && i_selftest_active)
      || (self_err_reg && !(link_loss || i_selftest_restart
      || i_error_reset));
   // Normal error set wins over any clear
   assign norm_err_next = (i_check_error && !i_selftest_active)
      || (norm_err_reg && !(link_loss || i_error_reset));

   // -----------------------------------------------------------------
   // Register read mux
   // -----------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      // Unmapped offsets read as zero
      case (i_reg_addr)
         LSAR_OFS_ALIAS: rd_mux = {alias_reg, 1'b0};
         LSAR_OFS_CNT_LO: rd_mux = cnt_wide[7:0];
         LSAR_OFS_CNT_HI: rd_mux = cnt_wide[15:8];
         LSAR_OFS_STATUS: rd_mux = status_byte;
         default: rd_mux = LSAR_BYTE_ZERO;
      endcase
   end

   // -----------------------------------------------------------------
   // Configuration and counter registers
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         alias_reg <= LSAR_ALIAS_RST;
         cnt_reg <= CNT_W'(LSAR_CNT_RST);
      end else begin
         alias_reg <= alias_next;
         cnt_reg <= cnt_next;
      end
   end

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         link_reg <= 1'b0;
         vclk_reg <= 1'b0;
         lost_reg <= 1'b0;
         self_err_reg <= 1'b0;
         norm_err_reg <= 1'b0;
      end else begin
         link_reg <= i_link_detect;
         vclk_reg <= i_video_input_clock_present;
         lost_reg <= lost_next;
         self_err_reg <= self_err_next;
         norm_err_reg <= norm_err_next;
      end
   end

   // -----------------------------------------------------------------
   // Alias remap toward the back channel
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fwd_valid_reg <= 1'b0;
         fwd_addr_reg <= 7'h00;
      end else begin
         // Only aliased accesses are forwarded
         fwd_valid_reg <= alias_hit;
         if (alias_hit) begin
            fwd_addr_reg <= i_remote_target_address;
         end
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_reg <= LSAR_BYTE_ZERO;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= i_reg_rd;
         if (i_reg_rd) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign o_reg_rdata = rdata_reg;
   assign o_reg_rvalid = rvalid_reg;
   assign o_fwd_valid = fwd_valid_reg;
   assign o_fwd_addr = fwd_addr_reg;
   assign o_remote_target_alias = alias_reg;
   assign o_general_link_status = status_byte;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   alias_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      wr_alias |=> o_remote_target_alias == $past(i_reg_wdata[7:1]))
      else $error("Alias field not written from bits 7:1");

   fwd_remap_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_host_valid && alias_reg != 7'h00 && i_host_addr == alias_reg)
      |=> o_fwd_valid && o_fwd_addr == $past(i_remote_target_address))
      else $error("Aliased access not remapped");

   zero_block_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (alias_reg == 7'h00) ##1 (alias_reg == 7'h00) |-> !o_fwd_valid)
      else $error("Forward with zero alias");

   cnt_incr_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_check_error && !i_error_reset && !cnt_full)
      |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
      else $error("Check error not counted");

   cnt_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_error_reset && !i_check_error) [*2] |-> cnt_reg == '0)
      else $error("Counter not cleared by error reset");

   lost_sticky_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      link_loss ##1 !i_error_reset [*3] |-> o_general_link_status[LSAR_ST_LOST])
      else $error("Link lost flag not held");

   self_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_selftest_restart && !(i_check_error && i_selftest_active))
      |=> !o_general_link_status[LSAR_ST_SELF_ERR])
      else $error("Self-test error not cleared on restart");

   norm_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_check_error && !i_selftest_active)
      |=> o_general_link_status[LSAR_ST_NORM_ERR]
      && (!$stable(cnt_reg) || $past(cnt_full) || $past(i_error_reset)))
      else $error("Normal error flag not set");

   link_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(i_link_detect) |=> o_general_link_status[LSAR_ST_LINK])
      else $error("Link presence not reported");

   vclk_bit_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      i_video_input_clock_present |=> o_general_link_status[LSAR_ST_VCLK])
      else $error("Video clock presence not reported");

   // -----------------------------------------------------------------
   // Further checks on read port, remap, counter and flags
   // -----------------------------------------------------------------
   rd_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      i_reg_rd |=> o_reg_rvalid)
      else $error("Read valid missing after read strobe");

   rd_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !i_reg_rd |=> !o_reg_rvalid)
      else $error("Read valid without read strobe");

   cnt_read_lo_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_reg_rd && i_reg_addr == LSAR_OFS_CNT_LO) |=> o_reg_rdata == $past(cnt_wide[7:0]))
      else $error("Counter low byte read wrong");

   cnt_read_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_reg_rd && i_reg_addr == LSAR_OFS_CNT_HI) |=> o_reg_rdata == $past(cnt_wide[15:8]))
      else $error("Counter high byte read wrong");

   alias_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !wr_alias |=> $stable(o_remote_target_alias))
      else $error("Alias field changed without write");

   fwd_miss_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !(i_host_valid && i_host_addr == alias_reg) |=> !o_fwd_valid)
      else $error("Forward without alias match");

   fwd_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !o_fwd_valid |-> $stable(o_fwd_addr))
      else $error("Forward address changed without forward");

   zero_alias_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (alias_reg == 7'h00) |=> !o_fwd_valid)
      else $error("Zero alias let a forward through");

   cnt_full_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (cnt_full && !i_error_reset) |=> cnt_full)
      else $error("Full counter wrapped");

   cnt_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (!i_check_error && !i_error_reset) |=> $stable(cnt_reg))
      else $error("Counter moved without error");

   cnt_reset_hit_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_error_reset && i_check_error) |=> cnt_reg == CNT_W'(1))
      else $error("Error during reset not counted once");

   lost_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      link_loss |=> o_general_link_status[LSAR_ST_LOST])
      else $error("Link lost flag not set");

   lost_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_error_reset && !link_loss) |=> !o_general_link_status[LSAR_ST_LOST])
      else $error("Link lost flag not cleared");

   self_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_check_error && i_selftest_active) |=> o_general_link_status[LSAR_ST_SELF_ERR])
      else $error("Self-test error flag not set");

   self_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      ((link_loss || i_error_reset) && !(i_check_error && i_selftest_active))
      |=> !o_general_link_status[LSAR_ST_SELF_ERR])
      else $error("Self-test error flag not cleared");

   norm_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      ((link_loss || i_error_reset) && !(i_check_error && !i_selftest_active))
      |=> !o_general_link_status[LSAR_ST_NORM_ERR])
      else $error("Normal error flag not cleared");

   link_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !i_link_detect |=> !o_general_link_status[LSAR_ST_LINK])
      else $error("Link shown present while absent");

   vclk_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
      !i_video_input_clock_present |=> !o_general_link_status[LSAR_ST_VCLK])
      else $error("Video clock shown present while absent");

endmodule : lsar_regs

// ==== hw/lsar_pkg.sv ====
// Purpose: Shared constants for the link status and alias register bank
// Assumes: 8-bit register port, 7-bit bus addresses
// Notes: Offsets are byte addresses of the serial control register map
package lsar_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] LSAR_OFS_ALIAS = 8'h08;  // remote_target_alias
   localparam logic [7:0] LSAR_OFS_CNT_LO = 8'h0A; // check_error_count_low
   localparam logic [7:0] LSAR_OFS_CNT_HI = 8'h0B; // check_error_count_high
   localparam logic [7:0] LSAR_OFS_STATUS = 8'h0C; // general_link_status
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int LSAR_ALIAS_LSB = 1;     // Alias field is bits 7:1
   localparam int LSAR_ST_LINK = 0;       // Link present
   localparam int LSAR_ST_NORM_ERR = 1;   // Normal-traffic check error
   localparam int LSAR_ST_VCLK = 2;       // Video input clock present
   localparam int LSAR_ST_SELF_ERR = 3;   // Self-test check error
   localparam int LSAR_ST_LOST = 4;       // Sticky link lost
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [6:0] LSAR_ALIAS_RST = 7'h00;
   localparam logic [15:0] LSAR_CNT_RST = 16'h0000;
   localparam logic [7:0] LSAR_BYTE_ZERO = 8'h00;
endpackage : lsar_pkg

// ==== dv/lsar_remote_model.sv ====
// Purpose: Remote receiver model at the back channel
// Assumes: Error bursts send one check error each cycle
// Notes: Logs forwarded aliased transactions
`timescale 1ns/100ps
module lsar_remote_model (
   input wire logic i_sys_clk,
   input wire logic i_arst_n,
   input wire logic i_err_go,         // Start an error burst
   input wire logic [15:0] i_err_num, // Burst length
   input wire logic i_link_want,      // Cable connected
   input wire logic i_fwd_valid,
   input wire logic [6:0] i_fwd_addr,
   output logic o_check_error,
   output logic o_link_detect,
   output logic [15:0] o_fwd_cnt,     // Forwarded transactions seen
   output logic [6:0] o_fwd_last      // Last forwarded address
);
   logic [15:0] left_reg; // Error pulses still to send
   assign o_check_error = (left_reg != 16'h0000);
   assign o_link_detect = i_link_want;
   // Burst countdown and forward log
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         left_reg <= 16'h0000;
         o_fwd_cnt <= 16'h0000;
         o_fwd_last <= 7'h00;
      end else begin
         if (i_err_go) begin
            left_reg <= i_err_num;
         end else if (o_check_error) begin
            left_reg <= left_reg - 16'h0001;
         end
         if (i_fwd_valid) begin
            o_fwd_cnt <= o_fwd_cnt + 16'h0001;
            o_fwd_last <= i_fwd_addr;
         end
      end
   end
endmodule : lsar_remote_model

// ==== dv/test_lsar_regs.sv ====
// Purpose: Self-checking bench for alias remap, error count and status
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Remote model makes check errors and the link level
`timescale 1ns/100ps
module test_lsar_regs;
   import lsar_pkg::*;
   logic i_sys_clk, i_arst_n, i_reg_wr, i_reg_rd, i_error_reset, i_host_valid, o_reg_rvalid;
   logic i_selftest_active, i_selftest_restart, vclk, chk_err, link, fwd_v, err_go, link_want;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, status;
   logic [6:0] tgt, host_addr, fwd_addr, alias_v, fwd_last, alias_o;
   logic [15:0] err_num, fwd_cnt, cnt_e;
   logic ln, ne, se, lo; // Expected status flags
   int errors, checks_done;
   lsar_regs DUT (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_error_reset(i_error_reset),
      .i_remote_target_address(tgt), .i_host_valid(i_host_valid), .i_host_addr(host_addr),
      .o_fwd_valid(fwd_v), .o_fwd_addr(fwd_addr), .i_check_error(chk_err),
      .i_selftest_active(i_selftest_active), .i_selftest_restart(i_selftest_restart),
      .i_link_detect(link), .i_video_input_clock_present(vclk),
      .o_remote_target_alias(alias_o), .o_general_link_status(status));
   lsar_remote_model remote (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_err_go(err_go),
      .i_err_num(err_num), .i_link_want(link_want), .i_fwd_valid(fwd_v), .i_fwd_addr(fwd_addr),
      .o_check_error(chk_err), .o_link_detect(link), .o_fwd_cnt(fwd_cnt),
      .o_fwd_last(fwd_last));
   // Compare and count
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (e !== g) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Verdict and end of run
   task automatic complete_run;
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   // Wait n edges, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : cyc
   // One register read with expected data
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_reg_rd = 1'b1;
      i_reg_addr = a;
      cyc(1);
      i_reg_rd = 1'b0;
      chk("rvalid", 16'h0001, {15'h0000, o_reg_rvalid});
      chk("rdata", {8'h00, e}, {8'h00, o_reg_rdata});
      cyc(1);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      cyc(1);
      i_reg_wr = 1'b0;
      cyc(1);
   endtask : wr
   // Host access; hit expects remap to the target
   task automatic host(input logic [6:0] a, input logic hit);
      i_host_valid = 1'b1;
      host_addr = a;
      cyc(1);
      i_host_valid = 1'b0;
      chk("fwd valid", {15'h0000, hit}, {15'h0000, fwd_v});
      if (hit) begin
         chk("fwd addr", {9'h000, tgt}, {9'h000, fwd_addr});
      end
      cyc(1);
   endtask : host
   // Remote error burst, bounded wait for its end
   task automatic burst(input logic [15:0] n);
      err_go = 1'b1;
      err_num = n;
      cyc(1);
      err_go = 1'b0;
      for (int k = 0; k < 70000 && chk_err !== 1'b0; k++) begin
         cyc(1);
      end
      if (chk_err !== 1'b0) begin
         chk("burst end", 16'h0000, {15'h0000, chk_err});
         complete_run();
      end
      cyc(2);
      cnt_e = cnt_e + n;
   endtask : burst
   // Expected status byte from the modelled flags
   function automatic logic [7:0] exp_sts(input logic l, input logic n, input logic v,
      input logic s, input logic o);
      return {3'b000, o, s, v, n, l};
   endfunction : exp_sts
   // Status through the register port and on the status output
   task automatic sts;
      rd(LSAR_OFS_STATUS, exp_sts(ln, ne, vclk, se, lo));
      chk("status port", {8'h00, exp_sts(ln, ne, vclk, se, lo)}, {8'h00, status});
   endtask : sts
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   // Main sequence
   initial begin
      {i_arst_n, i_reg_wr, i_reg_rd, i_error_reset, i_host_valid, err_go} = 6'h00;
      {i_selftest_active, i_selftest_restart, vclk, link_want} = 4'h3;
      {i_reg_addr, i_reg_wdata, tgt, host_addr, err_num, cnt_e} = 62'h0;
      {ln, ne, se, lo} = 4'h8;
      errors = 0;
      checks_done = 0;
      void'($urandom(32'h31DA));
      cyc(12);
      i_arst_n = 1'b1;
      cyc(3);
      rd(LSAR_OFS_ALIAS, 8'h00);
      rd(LSAR_OFS_CNT_LO, 8'h00);
      rd(LSAR_OFS_CNT_HI, 8'h00);
      sts();
      rd(8'h09, 8'h00);
      host(7'($urandom), 1'b0);
      for (int i = 0; i < 8; i++) begin
         alias_v = 7'($urandom_range(127, 1));
         tgt = 7'($urandom);
         wr(LSAR_OFS_ALIAS, {alias_v, 1'b1});
         rd(LSAR_OFS_ALIAS, {alias_v, 1'b0});
         chk("alias", {9'h000, alias_v}, {9'h000, alias_o});
         host(alias_v, 1'b1);
         host(alias_v ^ 7'h01, 1'b0);
      end
      chk("fwd count", 16'h0008, fwd_cnt);
      chk("fwd last", {9'h000, tgt}, {9'h000, fwd_last});
      wr(LSAR_OFS_ALIAS, 8'h00);
      host(alias_v, 1'b0);
      host(7'h00, 1'b0);
      wr(LSAR_OFS_CNT_LO, 8'hFF);
      rd(LSAR_OFS_CNT_LO, 8'h00);
      burst(16'(256 + $urandom_range(300)));
      ne = 1'b1;
      rd(LSAR_OFS_CNT_LO, cnt_e[7:0]);
      rd(LSAR_OFS_CNT_HI, cnt_e[15:8]);
      sts();
      i_selftest_active = 1'b1;
      burst(16'h0001);
      se = 1'b1;
      sts();
      i_selftest_restart = 1'b1;
      cyc(1);
      i_selftest_restart = 1'b0;
      cyc(1);
      se = 1'b0;
      sts();
      burst(16'h0001);
      i_selftest_active = 1'b0;
      link_want = 1'b0;
      cyc(2);
      {ln, ne, se, lo} = 4'h1;
      sts();
      link_want = 1'b1;
      burst(16'h0001);
      {ln, ne} = 2'b11;
      sts();
      i_error_reset = 1'b1;
      cyc(2);
      i_error_reset = 1'b0;
      cyc(1);
      {ne, lo} = 2'b00;
      sts();
      rd(LSAR_OFS_CNT_LO, 8'h00);
      rd(LSAR_OFS_CNT_HI, 8'h00);
      vclk = 1'b0;
      cyc(2);
      sts();
      // Counter stops at full scale
      ne = 1'b1;
      burst(16'hFFFF);
      burst(16'h0002);
      rd(LSAR_OFS_CNT_LO, 8'hFF);
      rd(LSAR_OFS_CNT_HI, 8'hFF);
      sts();
      // Reset in mid-run returns alias, counter and error flags to zero
      wr(LSAR_OFS_ALIAS, 8'h5A);
      i_arst_n = 1'b0;
      cyc(2);
      i_arst_n = 1'b1;
      cyc(2);
      ne = 1'b0;
      chk("alias reset", 16'h0000, {9'h000, alias_o});
      rd(LSAR_OFS_CNT_HI, 8'h00);
      sts();
      complete_run();
   end
endmodule : test_lsar_regs
